// ---- lpccu_top.sv ----
// Clock control unit: source selection, low-power wait, clock events, AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none

module lpccu_top #(
    parameter int ADDR_W = 12,
    parameter int ALT_ABSENT = lpccu_pkg::ALT_ABSENT_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic raw_crystal_clock,
    input wire logic alternate_low_freq_clock,
    input wire logic pll_clock_tick,
    input wire logic pll_locked,
    input wire logic wait_exec,
    input wire logic wake_event,
    input wire logic halt_exec,
    input wire logic stop_exit,
    input wire logic ext_irq_pin,
    output logic system_clock_en,
    output logic core_clock_en,
    output logic clock_unit_irq_line,
    output logic crystal_osc_enable,
    output logic pll_enable,
    output logic main_regulator_off,
    output logic halt_reset_req,
    output logic wait_state
);
    localparam int ALT_CW = $clog2(ALT_ABSENT + 1);
    localparam logic [ALT_CW-1:0] ALT_MAX = ALT_CW'(ALT_ABSENT);
    localparam logic [2:0] IRQ_LOW = 3'(lpccu_pkg::IRQ_LOW_CYCLES);

    lpccu_pkg::lpccu_ctl_t ctl;
    logic [7:0] core_mode;
    logic [7:0] pll_cfg;
    logic halt_en;
    logic xt_div16;
    logic pll_choice;
    logic halted;
    lpccu_pkg::lpccu_src_t cur_src;

    // Bus write path
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire [7:0] wr_idx = aw_addr[9:2];
    wire wr_hit = aw_addr[ADDR_W-1:10] == '0 && aw_addr[1:0] == 2'h0;
    wire wr_en = wr_go && wr_hit && w_lane0;
    wire wr_mode = wr_en && wr_idx == lpccu_pkg::IDX_CORE_MODE;
    wire wr_ctl = wr_en && wr_idx == lpccu_pkg::IDX_CLK_CTL;
    wire wr_reg = wr_en && wr_idx == lpccu_pkg::IDX_REG_CTL;
    wire wr_flag = wr_en && wr_idx == lpccu_pkg::IDX_CLK_FLAG;
    wire wr_pll = wr_en && wr_idx == lpccu_pkg::IDX_PLL_CFG;
    wire wr_known = wr_idx == lpccu_pkg::IDX_CORE_MODE || wr_idx == lpccu_pkg::IDX_CLK_CTL
        || wr_idx == lpccu_pkg::IDX_REG_CTL || wr_idx == lpccu_pkg::IDX_CLK_FLAG
        || wr_idx == lpccu_pkg::IDX_PLL_CFG;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= lpccu_pkg::RESP_OKAY;
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_hs)
            begin
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_hit && wr_known) ? lpccu_pkg::RESP_OKAY
                                                    : lpccu_pkg::RESP_DECERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Input edge detection; pins are synchronous to aclk
    logic xtal_q;
    logic alt_q;
    logic halve_ph;
    logic [3:0] d16_cnt;
    logic [ALT_CW-1:0] alt_idle;
    wire osc_on = crystal_osc_enable;
    wire xtal_rise = raw_crystal_clock && !xtal_q && osc_on;
    wire half_tick = xtal_rise && (!core_mode[lpccu_pkg::BIT_HALVE] || halve_ph);
    wire d16_tick = half_tick && d16_cnt == lpccu_pkg::DIV16_LAST;
    wire alt_rise = alternate_low_freq_clock && !alt_q;
    wire alt_present = alt_idle != ALT_MAX;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            xtal_q <= 1'b0;
            alt_q <= 1'b0;
            halve_ph <= 1'b0;
            d16_cnt <= 4'h0;
            alt_idle <= ALT_MAX;
        end
        else
        begin
            xtal_q <= raw_crystal_clock;
            alt_q <= alternate_low_freq_clock;
            if (xtal_rise)
                halve_ph <= !halve_ph;
            if (half_tick)
                d16_cnt <= d16_cnt + 4'h1;
            if (alt_rise)
                alt_idle <= '0;
            else if (alt_idle != ALT_MAX)
                alt_idle <= alt_idle + ALT_CW'(1);
        end
    end

    // Source selection; the same path serves register writes and wait
    wire lp_wait = wait_state && ctl.lpw_en;
    wire free_run = pll_cfg[lpccu_pkg::BIT_FREE_RUN];
    wire want_alt = (ctl.alt_req || (lp_wait && ctl.wait_choice)) && alt_present;
    wire want_div16 = !xt_div16 || lp_wait;
    wire pll_ok = pll_enable && (pll_locked || free_run);
    wire want_pll = pll_choice && pll_ok;
    wire alt_active = cur_src == lpccu_pkg::SRC_ALT;
    wire [4:0] flag_bits = {halt_en && alt_active, xt_div16, alt_active, pll_locked, pll_choice};
    lpccu_pkg::lpccu_flag_t flag;
    assign flag = lpccu_pkg::lpccu_flag_t'(flag_bits);
    lpccu_pkg::lpccu_src_t want_src;
    assign want_src = want_alt ? lpccu_pkg::SRC_ALT
                    : want_div16 ? lpccu_pkg::SRC_DIV16
                    : want_pll ? lpccu_pkg::SRC_PLL : lpccu_pkg::SRC_HALF;

    function automatic logic src_tick(input lpccu_pkg::lpccu_src_t s, input logic h,
                                      input logic d, input logic p, input logic a);
        unique case (s)
            lpccu_pkg::SRC_HALF: src_tick = h;
            lpccu_pkg::SRC_DIV16: src_tick = d;
            lpccu_pkg::SRC_PLL: src_tick = p;
            lpccu_pkg::SRC_ALT: src_tick = a;
        endcase
    endfunction : src_tick

    // The switch happens on a tick of the new source, so no short pulse can appear
    wire new_tick = src_tick(want_src, half_tick, d16_tick, pll_clock_tick, alt_rise);
    wire cur_tick = src_tick(cur_src, half_tick, d16_tick, pll_clock_tick, alt_rise);
    wire switching = want_src != cur_src;
    wire next_sys = !halted && (switching ? new_tick : cur_tick);
    wire next_osc = !halted && !(halt_en && alt_active);
    wire next_pll = !halted && !main_regulator_off && xt_div16
                    && !(lp_wait && !free_run);

    // Clock events for the interrupt line
    logic div16_q;
    logic alt_act_q;
    logic lock_q;
    logic [2:0] low_cnt;
    logic [2:0] pcnt;
    wire div16_act = cur_src == lpccu_pkg::SRC_DIV16;
    wire lock_evt = pll_enable && (pll_locked != lock_q);
    wire evt = (div16_act != div16_q) || (alt_active != alt_act_q) || lock_evt
               || stop_exit;
    wire int_low = low_cnt != 3'h0;
    wire next_line = ctl.irq_src ? !int_low : ext_irq_pin;
    wire [2:0] prs = core_mode[lpccu_pkg::PRS_LSB +: lpccu_pkg::PRS_W];
    wire pmatch = pcnt >= prs;
    wire next_core = next_sys && pmatch && !wait_state;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cur_src <= lpccu_pkg::SRC_HALF;
            system_clock_en <= 1'b0;
            core_clock_en <= 1'b0;
            crystal_osc_enable <= 1'b1;
            pll_enable <= 1'b1;
            pcnt <= 3'h0;
            div16_q <= 1'b0;
            alt_act_q <= 1'b0;
            // Start from the present lock level so reset release raises no false event
            lock_q <= pll_locked;
            low_cnt <= 3'h0;
            clock_unit_irq_line <= 1'b1;
        end
        else
        begin
            if (switching && new_tick)
                cur_src <= want_src;
            system_clock_en <= next_sys;
            core_clock_en <= next_core;
            crystal_osc_enable <= next_osc;
            pll_enable <= next_pll;
            if (next_sys)
                pcnt <= pmatch ? 3'h0 : pcnt + 3'h1;
            div16_q <= div16_act;
            alt_act_q <= alt_active;
            lock_q <= pll_locked;
            if (evt)
                low_cnt <= IRQ_LOW;
            else if (int_low)
                low_cnt <= low_cnt - 3'h1;
            clock_unit_irq_line <= next_line;
        end
    end

    // Software registers and wait / halt state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            core_mode <= lpccu_pkg::RST_CORE_MODE;
            ctl <= lpccu_pkg::lpccu_ctl_t'(lpccu_pkg::RST_CLK_CTL);
            pll_cfg <= lpccu_pkg::RST_PLL_CFG;
            main_regulator_off <= 1'b0;
            halt_en <= 1'b0;
            xt_div16 <= 1'b1;
            pll_choice <= 1'b0;
            wait_state <= 1'b0;
            halted <= 1'b0;
            halt_reset_req <= 1'b0;
        end
        else
        begin
            if (wr_mode)
                core_mode <= w_byte;
            if (wr_ctl)
                ctl <= lpccu_pkg::lpccu_ctl_t'(w_byte);
            // The wait clock choice acts as the request, so the alternate clock stays after wake
            if (lp_wait && ctl.wait_choice && alt_active)
                ctl.alt_req <= 1'b1;
            if (wr_pll)
                pll_cfg <= w_byte;
            if (wr_reg)
                main_regulator_off <= w_byte[lpccu_pkg::BIT_REG_OFF];
            if (wr_flag)
            begin
                halt_en <= w_byte[lpccu_pkg::BIT_HALT_EN];
                xt_div16 <= w_byte[lpccu_pkg::BIT_XT_DIV16];
            end
            // Hardware clear wins on low-power wait entry, regulator off, crystal off, xt_div16 clear or halt
            if ((wait_exec && ctl.lpw_en) || main_regulator_off || !crystal_osc_enable
                || !xt_div16 || halted)
                pll_choice <= 1'b0;
            else if (wr_flag)
                pll_choice <= w_byte[lpccu_pkg::BIT_PLL_CHOICE];
            // Entry wins over a coincident wake so the wait is not lost
            if (wait_exec)
                wait_state <= 1'b1;
            else if (wake_event)
                wait_state <= 1'b0;
            halt_reset_req <= halt_exec && ctl.halt_rst;
            if (halt_exec && !ctl.halt_rst)
                halted <= 1'b1;
        end
    end

    // Bus read path
    wire [7:0] rd_idx = s_axi_araddr[9:2];
    wire rd_hit = s_axi_araddr[ADDR_W-1:10] == '0 && s_axi_araddr[1:0] == 2'h0;
    wire [7:0] rd_byte = rd_idx == lpccu_pkg::IDX_CORE_MODE ? core_mode
                       : rd_idx == lpccu_pkg::IDX_CLK_CTL ? 8'(ctl)
                       : rd_idx == lpccu_pkg::IDX_REG_CTL
                         ? 8'(main_regulator_off) << lpccu_pkg::BIT_REG_OFF
                       : rd_idx == lpccu_pkg::IDX_CLK_FLAG ? {3'h0, flag}
                       : rd_idx == lpccu_pkg::IDX_PLL_CFG ? pll_cfg : 8'h00;
    wire rd_known = rd_idx == lpccu_pkg::IDX_CORE_MODE || rd_idx == lpccu_pkg::IDX_CLK_CTL
        || rd_idx == lpccu_pkg::IDX_REG_CTL || rd_idx == lpccu_pkg::IDX_CLK_FLAG
        || rd_idx == lpccu_pkg::IDX_PLL_CFG;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= lpccu_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_hit ? rd_byte : 8'h00};
            s_axi_rresp <= (rd_hit && rd_known) ? lpccu_pkg::RESP_OKAY
                                                : lpccu_pkg::RESP_DECERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_evt_internal;
        evt && ctl.irq_src;
    endsequence
    sequence seq_line_low;
        !clock_unit_irq_line;
    endsequence

    AST_CORE_STOP: assert property (wait_state |=> !core_clock_en)
        else $error("core clock ran during wait");
    AST_LP_PLL_OFF: assert property (lp_wait && !free_run |=> !pll_enable)
        else $error("PLL left on in low-power wait");
    AST_FREE_RUN: assert property (lp_wait && free_run && xt_div16 && !halted
                                   && !main_regulator_off |=> pll_enable)
        else $error("PLL stopped despite free run");
    AST_ALT_PRESENT: assert property ($rose(alt_active) |-> $past(alt_present))
        else $error("absent alternate clock selected");
    AST_OSC_STOP: assert property (halt_en && alt_active |=> !crystal_osc_enable)
        else $error("crystal not stopped");
    AST_PLL_CLEAR: assert property (wait_exec && ctl.lpw_en |=> !pll_choice)
        else $error("PLL choice not cleared on wait");
    AST_REG_OFF: assert property (main_regulator_off |=> !pll_choice)
        else $error("PLL choice kept with regulator off");
    AST_IRQ_FALL: assert property (seq_evt_internal |-> ##2 seq_line_low)
        else $error("clock event gave no falling edge");
    AST_IRQ_ROUTE: assert property (!ctl.irq_src |=>
                                    clock_unit_irq_line == $past(ext_irq_pin))
        else $error("external pin not routed");
    AST_CORE_EQ: assert property (prs == 3'h0 && !wait_state |=>
                                  core_clock_en == system_clock_en)
        else $error("core clock differs with no prescale");
    AST_HALT_RST: assert property (halt_exec && ctl.halt_rst |=> halt_reset_req)
        else $error("halt reset not issued");
endmodule : lpccu_top

`default_nettype wire

// ---- lpccu_pkg.sv ----
// Package of constants and types for the low-power clock control unit
package lpccu_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CORE_MODE = 8'hEB;
    localparam logic [7:0] IDX_CLK_CTL = 8'hF0;
    localparam logic [7:0] IDX_REG_CTL = 8'hF1;
    localparam logic [7:0] IDX_CLK_FLAG = 8'hF2;
    localparam logic [7:0] IDX_PLL_CFG = 8'hF6;
    localparam logic [7:0] RST_CORE_MODE = 8'hE0;
    localparam logic [7:0] RST_CLK_CTL = 8'h00;
    localparam logic [7:0] RST_PLL_CFG = 8'h00;
    localparam int BIT_HALVE = 5;
    localparam int PRS_LSB = 2;
    localparam int PRS_W = 3;
    localparam int BIT_REG_OFF = 3;
    localparam int BIT_HALT_EN = 4;
    localparam int BIT_XT_DIV16 = 3;
    localparam int BIT_PLL_CHOICE = 0;
    localparam int BIT_FREE_RUN = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic [3:0] DIV16_LAST = 4'hF;
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int IRQ_LOW_NS = 200;
    localparam int IRQ_LOW_CYCLES = (IRQ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ALT_ABSENT_NS = 10000;
    localparam int ALT_ABSENT_CYCLES = ALT_ABSENT_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic irq_src;
        logic [2:0] test;
        logic halt_rst;
        logic alt_req;
        logic wait_choice;
        logic lpw_en;
    } lpccu_ctl_t;

    typedef struct packed {
        logic halt_en;
        logic xt_div16;
        logic alt_flag;
        logic lock;
        logic pll_choice;
    } lpccu_flag_t;

    typedef enum logic [1:0] {
        SRC_HALF,
        SRC_DIV16,
        SRC_PLL,
        SRC_ALT
    } lpccu_src_t;
endpackage : lpccu_pkg

// ---- low_power_clock_control_unit_test.sv ----
// Self-checking testbench for the low-power clock control unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("BAD %0t got %h exp %h", $time, (a), (b)); end end

module low_power_clock_control_unit_test;
    localparam logic [7:0] MOD = lpccu_pkg::IDX_CORE_MODE;
    localparam logic [7:0] CTL = lpccu_pkg::IDX_CLK_CTL;
    localparam logic [7:0] FLG = lpccu_pkg::IDX_CLK_FLAG;
    localparam logic [7:0] CFG = lpccu_pkg::IDX_PLL_CFG;
    localparam logic [7:0] REG = lpccu_pkg::IDX_REG_CTL;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp, r, b;
    logic awready, wready, bvalid, arready, rvalid;
    logic xtal = 0, alt = 0, pll_tick = 0, locked = 1, wait_x = 0, wake = 0, halt_x = 0;
    logic stop_x = 0, ext_pin = 1, alt_on = 0;
    logic sys_en, core_en, irq, osc_en, pll_en, reg_off, hrst, wst;
    logic [2:0] alt_cnt = 0;
    int failures = 0, checks = 0, s, c;

    lpccu_top #(.ADDR_W(12), .ALT_ABSENT(16)) uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .raw_crystal_clock(xtal), .alternate_low_freq_clock(alt), .pll_clock_tick(pll_tick),
        .pll_locked(locked), .wait_exec(wait_x), .wake_event(wake), .halt_exec(halt_x),
        .stop_exit(stop_x), .ext_irq_pin(ext_pin), .system_clock_en(sys_en),
        .core_clock_en(core_en), .clock_unit_irq_line(irq), .crystal_osc_enable(osc_en),
        .pll_enable(pll_en), .main_regulator_off(reg_off), .halt_reset_req(hrst),
        .wait_state(wst));

    always #25 aclk = ~aclk;

    // Crystal ticks every 2 cycles, alternate every 8, PLL every 2; a stopped alternate sits low
    always @(posedge aclk)
    begin
        xtal <= ~xtal;
        alt_cnt <= alt_cnt + 3'h1;
        alt <= alt_on & alt_cnt[2];
        pll_tick <= ~pll_tick;
    end

    task automatic give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    // Handshakes are judged at the falling edge, which sees what the next rising edge samples
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic aw_ok, w_ok, b_ok;
        @(posedge aclk);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h0, v};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            aw_ok = awvalid & awready;
            w_ok = wvalid & wready;
            b_ok = bvalid & bready;
            b = bresp;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        while (!b_ok);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] idx);
        logic a_ok, r_ok;
        @(posedge aclk);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            a_ok = arvalid & arready;
            r_ok = rvalid & rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (a_ok) arvalid <= 1'b0;
        end
        while (!r_ok);
        rready <= 1'b0;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask : idle

    task automatic count(input int n);
        s = 0;
        c = 0;
        repeat (n)
        begin
            @(negedge aclk);
            s += int'(sys_en === 1'b1);
            c += int'(core_en === 1'b1);
        end
    endtask : count

    task automatic pulse(input int k);
        @(posedge aclk);
        case (k)
            0: wait_x <= 1'b1;
            1: wake <= 1'b1;
            2: halt_x <= 1'b1;
            default: stop_x <= 1'b1;
        endcase
        @(posedge aclk);
        wait_x <= 1'b0;
        wake <= 1'b0;
        halt_x <= 1'b0;
        stop_x <= 1'b0;
    endtask : pulse

    // Bounded wait for the interrupt line to reach a level
    task automatic see_irq(input logic lvl, input int n);
        int hit;
        hit = 0;
        repeat (n)
        begin
            @(negedge aclk);
            if (irq === lvl) hit = 1;
            if (hit == 1) break;
        end
        `CHK(hit, 1)
    endtask : see_irq

    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        idle(8);
        aresetn <= 1'b1;
    endtask : do_reset

    task automatic t_regs;
        rd(MOD);
        `CHK(d, {24'h0, lpccu_pkg::RST_CORE_MODE})
        rd(CTL);
        `CHK(d, 32'h0)
        rd(8'h10);
        `CHK(r, lpccu_pkg::RESP_DECERR)
        wr(CTL, 8'h70);
        `CHK(b, lpccu_pkg::RESP_OKAY)
        rd(CTL);
        `CHK(d, 32'h70)
        wr(8'h10, 8'hFF);
        `CHK(b, lpccu_pkg::RESP_DECERR)
        wr(CTL, 8'h00);
    endtask : t_regs

    task automatic t_rates;
        count(64);
        `CHK(s, 16)
        wr(MOD, 8'hEC);
        idle(40);
        count(64);
        `CHK(c, 4)
        wr(MOD, 8'hFC);
        idle(40);
        count(64);
        `CHK(c, 2)
        wr(MOD, 8'hC0);
        idle(8);
        count(64);
        `CHK(s, 32)
        `CHK(c, 32)
        wr(MOD, 8'hE0);
    endtask : t_rates

    task automatic t_irq;
        @(posedge aclk);
        ext_pin <= 1'b0;
        idle(3);
        `CHK(irq, 1'b0)
        locked <= 1'b0;
        ext_pin <= 1'b1;
        idle(6);
        `CHK(irq, 1'b1)
        locked <= 1'b1;
        idle(12);
        wr(CTL, 8'h80);
        idle(12);
        `CHK(irq, 1'b1)
        locked <= 1'b0;
        see_irq(1'b0, 5);
        see_irq(1'b1, 12);
        @(posedge aclk);
        locked <= 1'b1;
        see_irq(1'b0, 5);
        see_irq(1'b1, 12);
        pulse(3);
        see_irq(1'b0, 5);
        see_irq(1'b1, 12);
    endtask : t_irq

    task automatic t_wait;
        wr(FLG, 8'h09);
        idle(8);
        count(64);
        `CHK(s, 32)
        wr(CTL, 8'h81);
        pulse(0);
        idle(2);
        `CHK(wst, 1'b1)
        `CHK(pll_en, 1'b0)
        see_irq(1'b0, 100);
        idle(100);
        count(256);
        `CHK(s, 4)
        `CHK(c, 0)
        rd(FLG);
        `CHK(d[0], 1'b0)
        pulse(1);
        idle(80);
        count(64);
        `CHK(c, 16)
        // After wake the PLL stays deselected until software restores it
        rd(FLG);
        `CHK(d[0], 1'b0)
        wr(CTL, 8'h00);
        pulse(0);
        idle(4);
        count(64);
        `CHK(s, 16)
        `CHK(c, 0)
        pulse(1);
        wr(CFG, 8'h80);
        wr(CTL, 8'h01);
        pulse(0);
        idle(2);
        `CHK(pll_en, 1'b1)
        pulse(1);
        wr(CFG, 8'h00);
        wr(FLG, 8'h00);
        idle(80);
        count(256);
        `CHK(s, 4)
        wr(FLG, 8'h08);
    endtask : t_wait

    task automatic t_alt;
        wr(CTL, 8'h84);
        idle(40);
        rd(FLG);
        `CHK(d[2], 1'b0)
        alt_on <= 1'b1;
        see_irq(1'b0, 60);
        idle(40);
        rd(FLG);
        `CHK(d[2], 1'b1)
        count(64);
        `CHK(s, 8)
        alt_on <= 1'b0;
        idle(60);
        rd(FLG);
        `CHK(d[2], 1'b0)
        wr(CTL, 8'h03);
        alt_on <= 1'b1;
        pulse(0);
        idle(60);
        count(64);
        `CHK(s, 8)
        pulse(1);
        rd(FLG);
        `CHK(d[2], 1'b1)
        wr(CTL, 8'h00);
        idle(20);
        rd(FLG);
        `CHK(d[2], 1'b0)
        wr(FLG, 8'h18);
        wr(CTL, 8'h04);
        idle(40);
        `CHK(osc_en, 1'b0)
    endtask : t_alt

    task automatic t_halt;
        wr(CTL, 8'h08);
        pulse(2);
        @(negedge aclk);
        `CHK(hrst, 1'b1)
        @(negedge aclk);
        `CHK(hrst, 1'b0)
        wr(CTL, 8'h00);
        pulse(2);
        idle(4);
        `CHK(osc_en, 1'b0)
        `CHK(pll_en, 1'b0)
        count(64);
        `CHK(s, 0)
    endtask : t_halt

    task automatic t_regulator;
        wr(REG, 8'h08);
        idle(2);
        `CHK(reg_off, 1'b1)
        wr(FLG, 8'h09);
        rd(FLG);
        `CHK(d[0], 1'b0)
    endtask : t_regulator

    // Whole run is under 8000 cycles; the limit leaves ample room
    initial
    begin
        repeat (30000) @(posedge aclk);
        failures++;
        give_verdict();
    end

    initial
    begin
        do_reset();
        t_regs();
        t_rates();
        t_irq();
        t_wait();
        t_halt();
        do_reset();
        t_alt();
        t_regulator();
        give_verdict();
    end
endmodule : low_power_clock_control_unit_test
`default_nettype wire
